// *** tpl_pkg.sv ***
// Purpose: constants for the probe edge latch unit
// Assumes: AXI4-Lite with 32-bit data, 50 MHz clock
// Notes: register numbers are word indices; byte address is index*4
package tpl_pkg;
	// register word indices; the bus sees four times these
	localparam logic [15:0] TPL_IDX_FUNC = 16'h60b8;
	localparam logic [15:0] TPL_IDX_STAT = 16'h60b9;
	localparam logic [15:0] TPL_IDX_RPOS = 16'h60ba;
	localparam logic [15:0] TPL_IDX_FPOS = 16'h60bb;
	localparam logic [15:0] TPL_IDX_RTS = 16'h60d1;
	localparam logic [15:0] TPL_IDX_FTS = 16'h60d2;
	// extra registers for the interrupt logic
	localparam logic [15:0] TPL_IDX_IRQ_STAT = 16'h6100;
	localparam logic [15:0] TPL_IDX_IRQ_MASK = 16'h6101;
	localparam int TPL_ADDR_W = 18;
	// function word fields
	localparam int TPL_FN_EN = 0;
	localparam int TPL_FN_CONT = 1;
	localparam int TPL_FN_RISE = 4;
	localparam int TPL_FN_FALL = 5;
	// status word fields
	localparam int TPL_ST_EN = 0;
	localparam int TPL_ST_RSTORED = 1;
	localparam int TPL_ST_FSTORED = 2;
	localparam int TPL_ST_RTOG = 6;
	localparam int TPL_ST_FTOG = 7;
	// interrupt bits: 0 rise captured, 1 fall captured
	localparam int TPL_IRQ_W = 2;
	localparam logic [15:0] TPL_FUNC_RESET = 16'h0000;
	// shortest probe phase that the pin driver must keep
	localparam real TPL_MIN_PHASE_MS = 0.5;
	localparam real TPL_CLK_MHZ = 50.0;
	localparam int TPL_MIN_PHASE_CYC = int'(TPL_MIN_PHASE_MS * 1000.0
		* TPL_CLK_MHZ);
	localparam logic [1:0] TPL_RESP_OKAY = 2'b00;
	localparam logic [1:0] TPL_RESP_SLVERR = 2'b10;
endpackage : tpl_pkg

// *** tpl_probe_model.sv ***
// Purpose: probe sensor and feedback source for the latch
// Assumes: feedback changes only with the pin
// Notes: n counts pin changes and tags pos and time
`timescale 1ns/1ps
`default_nettype none
module tpl_probe_model
	import tpl_pkg::*;
#(
	parameter int PHASE = TPL_MIN_PHASE_CYC
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	output logic probe_o,
	output logic [31:0] pos_o,
	output logic [31:0] ts_o
);
	int age; // cycles since the last pin change
	logic [15:0] n; // pin change count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			age <= 0;
			n <= 16'h0;
			probe_o <= 1'b0;
		end else if (level_i != probe_o && age >= PHASE) begin
			age <= 0;
			n <= n + 16'h1;
			probe_o <= level_i;
		end else begin
			age <= age + 1;
		end
	end
	// held for a whole phase, so capture timing cannot blur it
	assign pos_o = {16'h1000, n};
	assign ts_o = {16'h2000, n};
endmodule : tpl_probe_model
`default_nettype wire

// *** tpl_touch_probe.sv ***
// Purpose: probe 1 edge latch with AXI4-Lite register access
// Assumes: probe pin is asynchronous; position and time come on clk_i
// Notes: one read and up to two writes in flight; a read answers one cycle
//   after its address is taken, a write two after its later half
//
// How it works
// - function bits 0,4,5 enable and arm edges
// - enabled probe shows status bit 0
// - armed rising edge sets status bit 1
// - rising edge latches position and time
// - armed falling edge sets status bit 2
// - falling edge latches position and time
// - clearing bit 4 clears status bit 1
// - rise latches hold over disarm/rearm
// - setting bit 4 rearms rising capture
// - clearing bit 0 clears status 0-2
// - disable keeps all four latches
// - continuous mode toggles bit 7 per fall
// - continuous mode toggles bit 6 per rise
`timescale 1ns/1ps
`default_nettype none
module tpl_touch_probe
	import tpl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic probe_input_one_i,
	input wire logic [31:0] position_i,
	input wire logic [31:0] timestamp_i,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq_o
);
	// pin synchroniser and edge history
	logic sync_a;
	logic sync_b;
	logic probe_prev;
	// register state
	logic [15:0] func;
	logic [15:0] status;
	logic [31:0] rise_pos;
	logic [31:0] fall_pos;
	logic [31:0] rise_ts;
	logic [31:0] fall_ts;
	logic [TPL_IRQ_W-1:0] irq_stat;
	logic [TPL_IRQ_W-1:0] irq_mask;
	// bus state: captured write address/data halves
	logic aw_held;
	logic w_held;
	logic [TPL_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	// next values
	logic next_sync_a;
	logic next_sync_b;
	logic next_probe_prev;
	logic [15:0] next_func;
	logic [15:0] next_status;
	logic [31:0] next_rise_pos;
	logic [31:0] next_fall_pos;
	logic [31:0] next_rise_ts;
	logic [31:0] next_fall_ts;
	logic [TPL_IRQ_W-1:0] next_irq_stat;
	logic [TPL_IRQ_W-1:0] next_irq_mask;
	logic next_irq;
	logic next_aw_held;
	logic next_w_held;
	logic [TPL_ADDR_W-1:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	// next ready pulses
	logic next_awready;
	logic next_wready;
	logic next_arready;
	// decoded helpers
	logic rise_hit;
	logic fall_hit;
	logic do_write;
	logic [15:0] w_idx;
	logic [15:0] r_idx;
	logic [31:0] wmask;

	// probe edge detection on the second sync stage only
	always_comb begin
		// two-flop synchroniser
		// the first stage may be metastable; only the second is read
		next_sync_a = probe_input_one_i;
		next_sync_b = sync_a;
		next_probe_prev = sync_b;
		// no filter: phases of 0.5 ms are far above sync delay
		// qualify by enable and arm bits
		rise_hit = sync_b & ~probe_prev & func[TPL_FN_EN]
			& func[TPL_FN_RISE];
		fall_hit = ~sync_b & probe_prev & func[TPL_FN_EN]
			& func[TPL_FN_FALL];
	end

	// bus write capture; address and data may arrive in either order
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		do_write = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr[TPL_ADDR_W-1:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		// both halves held and no response pending: commit
		if (aw_held && w_held && !bvalid) begin
			do_write = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = TPL_RESP_SLVERR;
			if (w_idx == TPL_IDX_FUNC || w_idx == TPL_IDX_IRQ_STAT
				|| w_idx == TPL_IDX_IRQ_MASK) begin
				next_bresp = TPL_RESP_OKAY;
			end
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// ready pulses for one cycle while a half is free; the gap
		// between pulses keeps a taken half from being taken twice
		next_awready = !next_aw_held && !s_axi_awready;
		next_wready = !next_w_held && !s_axi_wready;
	end

	// byte lanes of the write data
	always_comb begin
		w_idx = aw_addr[TPL_ADDR_W-1:2];
		r_idx = s_axi_araddr[TPL_ADDR_W-1:2];
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{w_strb[i]}};
		end
	end

	// function word, status, latches and interrupts
	always_comb begin
		next_func = func;
		next_status = status;
		next_rise_pos = rise_pos;
		next_fall_pos = fall_pos;
		next_rise_ts = rise_ts;
		next_fall_ts = fall_ts;
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		// software writes first, so a same-cycle event wins below
		if (do_write && w_idx == TPL_IDX_FUNC) begin
			// master writes enable and arm bits
			next_func = (func & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
		end
		if (do_write && w_idx == TPL_IDX_IRQ_MASK) begin
			next_irq_mask = (irq_mask & ~wmask[TPL_IRQ_W-1:0])
				| (w_data[TPL_IRQ_W-1:0] & wmask[TPL_IRQ_W-1:0]);
		end
		if (do_write && w_idx == TPL_IDX_IRQ_STAT) begin
			// write one to clear
			next_irq_stat = irq_stat & ~(w_data[TPL_IRQ_W-1:0]
				& wmask[TPL_IRQ_W-1:0]);
		end
		// enable indication follows function bit 0
		next_status[TPL_ST_EN] = func[TPL_FN_EN];
		// rearm leaves flag clear until next edge
		if (!func[TPL_FN_RISE]) begin
			next_status[TPL_ST_RSTORED] = 1'b0;
		end
		if (!func[TPL_FN_FALL]) begin
			next_status[TPL_ST_FSTORED] = 1'b0;
		end
		// disable clears status bits 0 to 2
		if (!func[TPL_FN_EN]) begin
			next_status[TPL_ST_RSTORED] = 1'b0;
			next_status[TPL_ST_FSTORED] = 1'b0;
		end
		// limitation: with bit 1 clear every armed edge still captures;
		// only the toggle bits depend on continuous mode
		// latches change only on a qualified edge
		if (rise_hit) begin
			next_status[TPL_ST_RSTORED] = 1'b1;
			next_rise_pos = position_i;
			next_rise_ts = timestamp_i;
			next_irq_stat[0] = 1'b1;
			if (func[TPL_FN_CONT]) begin
				next_status[TPL_ST_RTOG] = ~status[TPL_ST_RTOG];
			end
		end
		if (fall_hit) begin
			next_status[TPL_ST_FSTORED] = 1'b1;
			next_fall_pos = position_i;
			next_fall_ts = timestamp_i;
			next_irq_stat[1] = 1'b1;
			if (func[TPL_FN_CONT]) begin
				next_status[TPL_ST_FTOG] = ~status[TPL_ST_FTOG];
			end
		end
		// irq is taken from the next values, so it rises in the same
		// cycle as the status bit that causes it
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// read channel: answer one cycle after the address is taken
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = TPL_RESP_OKAY;
			unique case (r_idx)
				TPL_IDX_FUNC: next_rdata = {16'h0000, func};
				TPL_IDX_STAT: next_rdata = {16'h0000, status};
				TPL_IDX_RPOS: next_rdata = rise_pos;
				TPL_IDX_FPOS: next_rdata = fall_pos;
				TPL_IDX_RTS: next_rdata = rise_ts;
				TPL_IDX_FTS: next_rdata = fall_ts;
				TPL_IDX_IRQ_STAT: next_rdata = {30'h0, irq_stat};
				TPL_IDX_IRQ_MASK: next_rdata = {30'h0, irq_mask};
				default: begin
					// unmapped index answers an error
					next_rdata = 32'h0000_0000;
					next_rresp = TPL_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		// arready pulses only while no answer is pending or due,
		// which keeps a single read in flight
		next_arready = !next_rvalid && !s_axi_arready;
	end

	// synchroniser and edge history registers
	// reset to the idle low level of the pin, so that no false rising
	// edge is seen in the first cycles after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// all stages at the idle level
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			probe_prev <= 1'b0;
		end else begin
			// shift the pin one stage per clock
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			probe_prev <= next_probe_prev;
		end
	end

	// write channel registers: held halves, response and ready pulses
	// the readies come straight from here, so no bus input reaches an
	// output through logic in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// nothing held, no response pending, readies low
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= TPL_RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			// register the next values of the write side
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
		end
	end

	// function word, status, latches and interrupt registers
	// the latches clear only at reset; disabling never touches them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// probe disabled and disarmed, nothing captured
			func <= TPL_FUNC_RESET;
			status <= 16'h0000;
			rise_pos <= 32'h0000_0000;
			fall_pos <= 32'h0000_0000;
			rise_ts <= 32'h0000_0000;
			fall_ts <= 32'h0000_0000;
			irq_stat <= '0;
			irq_mask <= '0;
			irq_o <= 1'b0;
		end else begin
			// register the next values of the probe state
			func <= next_func;
			status <= next_status;
			rise_pos <= next_rise_pos;
			fall_pos <= next_fall_pos;
			rise_ts <= next_rise_ts;
			fall_ts <= next_fall_ts;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq_o <= next_irq;
		end
	end

	// read channel registers
	// one read in flight: arready stays low while rvalid is pending
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// no answer pending, ready low
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= TPL_RESP_OKAY;
			s_axi_arready <= 1'b0;
		end else begin
			// register the next values of the read side
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_arready <= next_arready;
		end
	end

	// bus outputs read back by the next-value logic
	assign bvalid = s_axi_bvalid;
	assign bresp = s_axi_bresp;
	assign rvalid = s_axi_rvalid;
	assign rdata = s_axi_rdata;
	assign rresp = s_axi_rresp;

endmodule : tpl_touch_probe
`default_nettype wire

// *** tpl_touch_probe_assertions.sv ***
// Purpose: port checks for the probe latch
// Assumes: one clock, writes offer both halves together
// Notes: bound to tpl_touch_probe below
`timescale 1ns/1ps
`default_nettype none
module tpl_touch_probe_assertions
	import tpl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic [15:0] ridx = s_axi_araddr[17:2]; // read index
	// readable places of the map
	wire logic rmap = ridx inside {TPL_IDX_FUNC, TPL_IDX_STAT,
		TPL_IDX_RPOS, TPL_IDX_FPOS, TPL_IDX_RTS, TPL_IDX_FTS,
		TPL_IDX_IRQ_STAT, TPL_IDX_IRQ_MASK};
	// both write halves taken at one edge, to index i
	sequence s_wr(logic [15:0] i);
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr[17:2] == i;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr(s_axi_awaddr[17:2]) |-> ##2
		s_axi_bvalid) else $error("write answer late");
	a_func_okay: assert property (s_wr(TPL_IDX_FUNC) |-> ##2
		s_axi_bresp == TPL_RESP_OKAY) else $error("func write refused");
	a_status_ro: assert property (s_wr(TPL_IDX_STAT) |-> ##2
		s_axi_bresp == TPL_RESP_SLVERR) else $error("status written");
	a_read_next: assert property (s_rd |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_unmapped: assert property (s_rd ##0 !rmap |=> s_axi_rdata == 32'h0
		&& s_axi_rresp == TPL_RESP_SLVERR) else $error("unmapped read");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready not a pulse");
	a_irq_reset: assert property ($fell(rst_i) |-> !irq_o)
		else $error("irq after reset");
endmodule : tpl_touch_probe_assertions
bind tpl_touch_probe tpl_touch_probe_assertions u_chk (.clk_i, .rst_i,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .irq_o);
`default_nettype wire

// *** tpl_touch_probe_tb_top.sv ***
// Purpose: bench for the probe latch
// Assumes: probe phases shortened to 20 cycles
// Notes: arm, capture, disarm, rearm, irq, disable
`timescale 1ns/1ps
`default_nettype none
module tpl_touch_probe_tb_top;
	import tpl_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic lvl = 1'b0; // level asked of the probe
	logic probe, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq_o;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] pos, ts, s_axi_rdata;
	logic [31:0] s_axi_awaddr = 32'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_araddr = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	int mismatches = 0;
	int compares = 0;
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	tpl_probe_model #(.PHASE(20)) u_model (.clk_i, .rst_i, .level_i(lvl),
		.probe_o(probe), .pos_o(pos), .ts_o(ts));
	tpl_touch_probe DUT (.clk_i, .rst_i, .probe_input_one_i(probe),
		.position_i(pos), .timestamp_i(ts), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [15:0] i, input logic [31:0] d,
		input logic [1:0] e = TPL_RESP_OKAY, input logic [3:0] b = 4'hf);
		@(posedge clk_i);
		s_axi_awaddr <= {14'h0, i, 2'b00};
		s_axi_wdata <= d;
		s_axi_wstrb <= b;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (40) begin
			@(posedge clk_i);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, e});
	endtask : wr
	task automatic rd(input logic [15:0] i, input logic [31:0] x,
		input logic [1:0] e = TPL_RESP_OKAY);
		@(posedge clk_i);
		s_axi_araddr <= {14'h0, i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (40) begin
			@(posedge clk_i);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, x);
		chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, e});
	endtask : rd
	// move the pin; capture shows three cycles after it
	task automatic pin(input logic l);
		@(posedge clk_i);
		lvl <= l;
		repeat (60) begin
			@(posedge clk_i);
			if (probe == l)
				break;
		end
		repeat (4) @(posedge clk_i);
	endtask : pin
	// irq is registered: look at it once it has settled
	task automatic irq(input logic x);
		repeat (2) @(negedge clk_i);
		chk({31'h0, irq_o}, {31'h0, x});
	endtask : irq
	task automatic close_out;
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	initial begin
		repeat (2000) @(posedge clk_i);
		mismatches++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(TPL_IDX_IRQ_MASK, 32'h0);
		wr(TPL_IDX_FUNC, 32'h31);
		rd(TPL_IDX_STAT, 32'h1);
		pin(1'b1);
		rd(TPL_IDX_STAT, 32'h3);
		rd(TPL_IDX_RPOS, 32'h10000001);
		rd(TPL_IDX_RTS, 32'h20000001);
		pin(1'b0);
		rd(TPL_IDX_STAT, 32'h7);
		rd(TPL_IDX_FTS, 32'h20000002);
		wr(TPL_IDX_FUNC, 32'h21);
		rd(TPL_IDX_STAT, 32'h5);
		pin(1'b1);
		pin(1'b0);
		rd(TPL_IDX_STAT, 32'h5);
		rd(TPL_IDX_FPOS, 32'h10000004);
		wr(TPL_IDX_FUNC, 32'h33);
		rd(TPL_IDX_RPOS, 32'h10000001);
		pin(1'b1);
		rd(TPL_IDX_STAT, 32'h47);
		rd(TPL_IDX_RPOS, 32'h10000005);
		pin(1'b0);
		rd(TPL_IDX_STAT, 32'hc7);
		rd(TPL_IDX_IRQ_STAT, 32'h3);
		irq(1'b0);
		wr(TPL_IDX_IRQ_MASK, 32'h1);
		irq(1'b1);
		wr(TPL_IDX_IRQ_STAT, 32'h1);
		irq(1'b0);
		// no byte lane enabled: the mask must keep its value
		wr(TPL_IDX_IRQ_MASK, 32'h2, TPL_RESP_OKAY, 4'h0);
		rd(TPL_IDX_IRQ_MASK, 32'h1);
		wr(TPL_IDX_FUNC, 32'h0);
		rd(TPL_IDX_STAT, 32'hc0);
		pin(1'b1);
		rd(TPL_IDX_RTS, 32'h20000005);
		rd(TPL_IDX_FPOS, 32'h10000006);
		rd(16'h0000, 32'h0, TPL_RESP_SLVERR);
		wr(TPL_IDX_STAT, 32'h1, TPL_RESP_SLVERR);
		rd(TPL_IDX_STAT, 32'hc0);
		close_out();
	end
endmodule : tpl_touch_probe_tb_top
`default_nettype wire
